/* File: mem_model.sv */
// behavioural byte memory answering the execution unit's requests
`default_nettype none
module mem_model (
   input  wire logic                core_clk,
   input  wire logic                rst_n,
   input  wire logic                slow,
   input  wire shift_pkg::mem_req_t mem_out,
   output var  shift_pkg::mem_rsp_t mem_in
);
   import shift_pkg::*;
   logic [7:0] mem [0:131071];
   logic [1:0] dly_r;
   // slow mode holds each answer back three cycles so the request must stand
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mem_in <= '0;
         dly_r  <= 2'd0;
      end
      else
      begin
         mem_in.ack   <= 1'b0;
         // between answers the read byte flips to its complement every cycle
         mem_in.rdata <= ~mem_in.rdata;
         dly_r        <= 2'd0;
         if (mem_out.req && !mem_in.ack && slow && dly_r != 2'd3)
            dly_r <= dly_r + 2'd1;
         else if (mem_out.req && !mem_in.ack)
         begin
            mem_in.ack <= 1'b1;
            if (mem_out.we)
               mem[{mem_out.space, mem_out.addr}] <= mem_out.wdata;
            else
               mem_in.rdata <= mem[{mem_out.space, mem_out.addr}];
         end
      end
   end
endmodule
`default_nettype wire

/* File: shift_pkg.sv */
// constants, command layout and carriers for the transfer and shift execution unit
`default_nettype none
package shift_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] A_CMD  = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_ACC  = 8'h08;
   localparam logic [7:0] A_FLAG = 8'h0c;
   localparam logic [7:0] A_XP   = 8'h10;
   localparam logic [7:0] A_YP   = 8'h14;
   localparam logic [7:0] A_UP   = 8'h18;
   localparam logic [7:0] A_SP   = 8'h1c;
   localparam logic [7:0] A_PC   = 8'h20;
   localparam logic [7:0] A_TMP  = 8'h24;
   localparam logic [7:0] A_DIR  = 8'h28;
   // reset values and fixed bytes
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [15:0] RST_WORD  = 16'h0000;
   localparam logic [7:0]  ZERO_BYTE = 8'h00;
   localparam logic [15:0] ONE_WORD  = 16'h0001;
   localparam int          BUSY_BIT  = 0;
   localparam int          FLAG_LSB  = 4;
   // pair indices
   localparam logic [1:0] PAIR_X = 2'd0;
   localparam logic [1:0] PAIR_Y = 2'd1;
   localparam logic [1:0] PAIR_U = 2'd2;
   // index source / destination selector
   localparam logic [1:0] SRC_PAIR  = 2'd0;
   localparam logic [1:0] SRC_STACK = 2'd1;
   localparam logic [1:0] SRC_PC    = 2'd2;
   // command codes
   localparam logic [5:0] OP_NOP            = 6'h00;
   localparam logic [5:0] OP_LOAD_ACC_REG   = 6'h01;
   localparam logic [5:0] OP_LOAD_ACC_MEM   = 6'h02;
   localparam logic [5:0] OP_LOAD_DEC       = 6'h03;
   localparam logic [5:0] OP_LOAD_INC       = 6'h04;
   localparam logic [5:0] OP_LOAD_IMM_ACC   = 6'h05;
   localparam logic [5:0] OP_LOAD_IMM_REG   = 6'h06;
   localparam logic [5:0] OP_LOAD_IMM_STACK = 6'h07;
   localparam logic [5:0] OP_LOAD_INDEX     = 6'h08;
   localparam logic [5:0] OP_STORE_ACC_REG  = 6'h09;
   localparam logic [5:0] OP_STORE_ACC_MEM  = 6'h0a;
   localparam logic [5:0] OP_STORE_DEC      = 6'h0b;
   localparam logic [5:0] OP_STORE_INC      = 6'h0c;
   localparam logic [5:0] OP_STORE_INDEX    = 6'h0d;
   localparam logic [5:0] OP_SAVE_ACC       = 6'h0e;
   localparam logic [5:0] OP_SAVE_PAIR      = 6'h0f;
   localparam logic [5:0] OP_RESTORE_ACC    = 6'h10;
   localparam logic [5:0] OP_RESTORE_PAIR   = 6'h11;
   localparam logic [5:0] OP_ACC_TO_TEMP    = 6'h12;
   localparam logic [5:0] OP_TEMP_TO_ACC    = 6'h13;
   localparam logic [5:0] OP_BLOCK_COPY     = 6'h14;
   localparam logic [5:0] OP_CMP_MEM_ADV    = 6'h15;
   localparam logic [5:0] OP_ROT_LEFT       = 6'h16;
   localparam logic [5:0] OP_ROT_RIGHT      = 6'h17;
   localparam logic [5:0] OP_SHIFT_LEFT     = 6'h18;
   localparam logic [5:0] OP_SHIFT_RIGHT    = 6'h19;
   localparam logic [5:0] OP_NIB_ROT_LEFT   = 6'h1a;
   localparam logic [5:0] OP_NIB_ROT_RIGHT  = 6'h1b;
   localparam logic [5:0] OP_NIB_SWAP       = 6'h1c;
   localparam logic [5:0] OP_CMP_REG        = 6'h1d;
   localparam logic [5:0] OP_CMP_MEM        = 6'h1e;

   typedef struct packed {
      logic [7:0] imm2;
      logic [7:0] imm;
      logic [2:0] rsvd;
      logic [1:0] src;
      logic       space;
      logic       direct;
      logic       high;
      logic [1:0] sel;
      logic [5:0] op;
   } cmd_t;

   typedef struct packed {
      logic v;
      logic z;
      logic h;
      logic c;
   } flags_t;

   typedef struct packed {
      logic        req;
      logic        we;
      logic        space;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } mem_req_t;

   typedef struct packed {
      logic       ack;
      logic [7:0] rdata;
   } mem_rsp_t;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WAIT} stt_t;
endpackage
`default_nettype wire

/* File: transfer_shift_exec.sv */
// execution unit for transfer, stack, block, rotate, shift and digit-rotate commands
//
// The placing of the registers and the APB register port were decided locally.
`default_nettype none
// Notes on behaviour
// - load accumulator from half-register or memory; zero flag set when byte is 00
// - load from pointer address into accumulator, set zero flag, then pointer minus one
// - load from pointer address into accumulator, set zero flag, then pointer plus one
// - immediate to accumulator sets zero; to half-register or stack pointer no flags
// - copy pair, stack pointer or program counter into first pair, flags unchanged
// - store accumulator to half-register or memory, flags unchanged
// - store accumulator at pointer address, then pointer minus one, no flags
// - store accumulator at pointer address, then pointer plus one, no flags
// - copy first pair into pair, stack pointer or program counter, no flags
// - save accumulator: write then stack minus one; pair: low, dec, high, dec
// - restore: stack plus one then read; accumulator sets zero flag; pair gets high then low, no flags
// - accumulator copied into temporary register
// - temporary copied into accumulator, zero flag set when value is 00
// - copy byte from first pair address to second pair address, both plus one
// - compare accumulator with byte at first pair, set flags, first pair plus one
// - rotate accumulator left through carry
// - rotate accumulator right through carry
// - shift accumulator left, bit 7 to carry, zero into bit 0
// - digit rotate left: memory gets its low digit high, acc high digit low
// - digit rotate right: memory gets acc low digit high, own high digit low
// - swap accumulator digits, flags unchanged
// - compare as acc plus inverted operand plus one; carry means greater or equal
module transfer_shift_exec (
   input  wire logic                core_clk,
   input  wire logic                rst_n,
   input  wire logic [7:0]          paddr,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [31:0]         pwdata,
   output var  logic [31:0]         prdata,
   output var  logic                pready,
   output var  logic                pslverr,
   output var  shift_pkg::mem_req_t mem_out,
   input  wire shift_pkg::mem_rsp_t mem_in
);
   import shift_pkg::*;

   cmd_t        cmd_r;
   flags_t      flag_r;
   stt_t        state_r;
   logic        step_r;
   logic [7:0]  acc_r;
   logic [7:0]  tmp_r;
   logic [7:0]  mdat_r;
   logic [15:0] pair_r [0:2];
   logic [15:0] sp_r;
   logic [15:0] pc_r;
   logic [15:0] dir_r;
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;
   mem_req_t    mem_r;

   logic [1:0]  pidx;
   logic [15:0] pv;
   logic [7:0]  rv;
   logic [15:0] ea;
   logic        mem_op;
   logic [15:0] m_addr;
   logic        m_we;
   logic [7:0]  m_wd;
   logic        m_space;
   logic        m_last;
   logic [31:0] rd_val;
   logic        rd_hit;
   logic        acc_phase;
   logic        wr_go;
   logic        busy;

   // operand minus subtrahend done as addition of the complement
   function automatic flags_t cmp_f(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      logic [4:0] l;
      flags_t     f;
      s = {1'b0, a} + {1'b0, ~b} + 9'h001;
      l = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
      f.c = s[8];
      f.h = l[4];
      f.z = (s[7:0] == ZERO_BYTE);
      f.v = (a[7] != b[7]) && (s[7] != a[7]);
      return f;
   endfunction

   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;
   assign mem_out = mem_r;

   // selector value 3 falls back to the third pair rather than reading nothing
   assign pidx      = (cmd_r.sel > PAIR_U) ? PAIR_U : cmd_r.sel;
   assign pv        = pair_r[pidx];
   assign rv        = cmd_r.high ? pv[15:8] : pv[7:0];
   assign ea        = cmd_r.direct ? dir_r : pv;
   assign busy      = (state_r != ST_IDLE);
   assign acc_phase = psel && penable && !pready_r;
   assign wr_go     = psel && penable && pready_r && pwrite;

   always_comb
   begin
      mem_op = 1'b0;
      case (cmd_r.op)
         OP_LOAD_ACC_MEM, OP_LOAD_DEC, OP_LOAD_INC, OP_STORE_ACC_MEM,
         OP_STORE_DEC, OP_STORE_INC, OP_SAVE_ACC, OP_SAVE_PAIR,
         OP_RESTORE_ACC, OP_RESTORE_PAIR, OP_BLOCK_COPY, OP_CMP_MEM_ADV,
         OP_NIB_ROT_LEFT, OP_NIB_ROT_RIGHT, OP_CMP_MEM: mem_op = 1'b1;
      endcase
   end

   // address, direction and data of the current memory step
   always_comb
   begin
      m_addr  = ea;
      m_we    = 1'b0;
      m_wd    = acc_r;
      m_space = cmd_r.space;
      m_last  = 1'b1;
      case (cmd_r.op)
         OP_LOAD_DEC, OP_LOAD_INC: m_addr = pv;
         OP_STORE_ACC_MEM: m_we = 1'b1;
         OP_STORE_DEC, OP_STORE_INC:
         begin
            m_addr = pv;
            m_we   = 1'b1;
         end
         OP_SAVE_ACC:
         begin
            m_addr  = sp_r;
            m_we    = 1'b1;
            m_space = 1'b0;
         end
         OP_SAVE_PAIR:
         begin
            m_addr  = sp_r;
            m_we    = 1'b1;
            m_wd    = step_r ? pv[15:8] : pv[7:0];
            m_space = 1'b0;
            m_last  = step_r;
         end
         OP_RESTORE_ACC:
         begin
            m_addr  = sp_r + ONE_WORD;
            m_space = 1'b0;
         end
         OP_RESTORE_PAIR:
         begin
            m_addr  = sp_r + ONE_WORD;
            m_space = 1'b0;
            m_last  = step_r;
         end
         OP_BLOCK_COPY:
         begin
            m_addr = step_r ? pair_r[PAIR_Y] : pair_r[PAIR_X];
            m_we   = step_r;
            m_wd   = mdat_r;
            m_last = step_r;
         end
         OP_CMP_MEM_ADV: m_addr = pair_r[PAIR_X];
         OP_NIB_ROT_LEFT:
         begin
            m_addr = pair_r[PAIR_X];
            m_we   = step_r;
            m_wd   = {mdat_r[3:0], acc_r[7:4]};
            m_last = step_r;
         end
         OP_NIB_ROT_RIGHT:
         begin
            m_addr = pair_r[PAIR_X];
            m_we   = step_r;
            m_wd   = {acc_r[3:0], mdat_r[7:4]};
            m_last = step_r;
         end
      endcase
   end

   // bus read mux
   always_comb
   begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      if (paddr == A_CMD)
         rd_val = cmd_r;
      else if (paddr == A_STAT)
         rd_val = {24'h00_0000, flag_r, 3'h0, busy};
      else if (paddr == A_ACC)
         rd_val = {24'h00_0000, acc_r};
      else if (paddr == A_FLAG)
         rd_val = {28'h000_0000, flag_r};
      else if (paddr == A_XP)
         rd_val = {16'h0000, pair_r[PAIR_X]};
      else if (paddr == A_YP)
         rd_val = {16'h0000, pair_r[PAIR_Y]};
      else if (paddr == A_UP)
         rd_val = {16'h0000, pair_r[PAIR_U]};
      else if (paddr == A_SP)
         rd_val = {16'h0000, sp_r};
      else if (paddr == A_PC)
         rd_val = {16'h0000, pc_r};
      else if (paddr == A_TMP)
         rd_val = {24'h00_0000, tmp_r};
      else if (paddr == A_DIR)
         rd_val = {16'h0000, dir_r};
      else
         rd_hit = 1'b0;
   end

   // slave answers one cycle into the access phase
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end
      else
      begin
         pready_r  <= acc_phase;
         pslverr_r <= acc_phase && !rd_hit;
         if (acc_phase && !pwrite)
            prdata_r <= rd_val;
         else if (!acc_phase)
            prdata_r <= 32'h0000_0000;
      end
   end

   // sequencer and architectural state; bus writes land only while idle
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r        <= ST_IDLE;
         step_r         <= 1'b0;
         cmd_r          <= '0;
         flag_r         <= '0;
         acc_r          <= RST_BYTE;
         tmp_r          <= RST_BYTE;
         mdat_r         <= RST_BYTE;
         pair_r[PAIR_X] <= RST_WORD;
         pair_r[PAIR_Y] <= RST_WORD;
         pair_r[PAIR_U] <= RST_WORD;
         sp_r           <= RST_WORD;
         pc_r           <= RST_WORD;
         dir_r          <= RST_WORD;
         mem_r          <= '0;
      end
      else
      begin
         case (state_r)
            ST_IDLE:
            begin
               if (wr_go)
               begin
                  if (paddr == A_CMD)
                  begin
                     cmd_r   <= pwdata;
                     step_r  <= 1'b0;
                     state_r <= ST_EXEC;
                  end
                  else if (paddr == A_ACC)
                     acc_r <= pwdata[7:0];
                  else if (paddr == A_FLAG)
                     flag_r <= pwdata[3:0];
                  else if (paddr == A_XP)
                     pair_r[PAIR_X] <= pwdata[15:0];
                  else if (paddr == A_YP)
                     pair_r[PAIR_Y] <= pwdata[15:0];
                  else if (paddr == A_UP)
                     pair_r[PAIR_U] <= pwdata[15:0];
                  else if (paddr == A_SP)
                     sp_r <= pwdata[15:0];
                  else if (paddr == A_PC)
                     pc_r <= pwdata[15:0];
                  else if (paddr == A_TMP)
                     tmp_r <= pwdata[7:0];
                  else if (paddr == A_DIR)
                     dir_r <= pwdata[15:0];
               end
            end
            ST_EXEC:
            begin
               if (mem_op)
               begin
                  mem_r.req   <= 1'b1;
                  mem_r.we    <= m_we;
                  mem_r.space <= m_space;
                  mem_r.addr  <= m_addr;
                  mem_r.wdata <= m_wd;
                  state_r     <= ST_WAIT;
               end
               else
               begin
                  state_r <= ST_IDLE;
                  case (cmd_r.op)
                     OP_LOAD_ACC_REG:
                     begin
                        acc_r    <= rv;
                        flag_r.z <= (rv == ZERO_BYTE);
                     end
                     OP_LOAD_IMM_ACC:
                     begin
                        acc_r    <= cmd_r.imm;
                        flag_r.z <= (cmd_r.imm == ZERO_BYTE);
                     end
                     OP_LOAD_IMM_REG:
                        if (cmd_r.high)
                           pair_r[pidx][15:8] <= cmd_r.imm;
                        else
                           pair_r[pidx][7:0] <= cmd_r.imm;
                     OP_LOAD_IMM_STACK: sp_r <= {cmd_r.imm, cmd_r.imm2};
                     OP_LOAD_INDEX:
                        if (cmd_r.src == SRC_STACK)
                           pair_r[PAIR_X] <= sp_r;
                        else if (cmd_r.src == SRC_PC)
                           pair_r[PAIR_X] <= pc_r;
                        else
                           pair_r[PAIR_X] <= pv;
                     OP_STORE_ACC_REG:
                        if (cmd_r.high)
                           pair_r[pidx][15:8] <= acc_r;
                        else
                           pair_r[pidx][7:0] <= acc_r;
                     // a new program counter redirects the fetch unit outside
                     OP_STORE_INDEX:
                        if (cmd_r.src == SRC_STACK)
                           sp_r <= pair_r[PAIR_X];
                        else if (cmd_r.src == SRC_PC)
                           pc_r <= pair_r[PAIR_X];
                        else
                           pair_r[pidx] <= pair_r[PAIR_X];
                     OP_ACC_TO_TEMP: tmp_r <= acc_r;
                     OP_TEMP_TO_ACC:
                     begin
                        acc_r    <= tmp_r;
                        flag_r.z <= (tmp_r == ZERO_BYTE);
                     end
                     OP_ROT_LEFT:
                     begin
                        acc_r    <= {acc_r[6:0], flag_r.c};
                        flag_r.c <= acc_r[7];
                     end
                     OP_ROT_RIGHT:
                     begin
                        acc_r    <= {flag_r.c, acc_r[7:1]};
                        flag_r.c <= acc_r[0];
                     end
                     OP_SHIFT_LEFT:
                     begin
                        acc_r    <= {acc_r[6:0], 1'b0};
                        flag_r.c <= acc_r[7];
                     end
                     OP_SHIFT_RIGHT:
                     begin
                        acc_r    <= {1'b0, acc_r[7:1]};
                        flag_r.c <= acc_r[0];
                     end
                     OP_NIB_SWAP: acc_r <= {acc_r[3:0], acc_r[7:4]};
                     OP_CMP_REG: flag_r <= cmp_f(acc_r, rv);
                  endcase
               end
            end
            ST_WAIT:
            begin
               if (mem_in.ack)
               begin
                  mem_r.req <= 1'b0;
                  if (!mem_r.we)
                     mdat_r <= mem_in.rdata;
                  case (cmd_r.op)
                     OP_LOAD_ACC_MEM:
                     begin
                        acc_r    <= mem_in.rdata;
                        flag_r.z <= (mem_in.rdata == ZERO_BYTE);
                     end
                     OP_LOAD_DEC:
                     begin
                        acc_r        <= mem_in.rdata;
                        flag_r.z     <= (mem_in.rdata == ZERO_BYTE);
                        pair_r[pidx] <= pv - ONE_WORD;
                     end
                     OP_LOAD_INC:
                     begin
                        acc_r        <= mem_in.rdata;
                        flag_r.z     <= (mem_in.rdata == ZERO_BYTE);
                        pair_r[pidx] <= pv + ONE_WORD;
                     end
                     OP_STORE_DEC: pair_r[pidx] <= pv - ONE_WORD;
                     OP_STORE_INC: pair_r[pidx] <= pv + ONE_WORD;
                     OP_SAVE_ACC, OP_SAVE_PAIR: sp_r <= sp_r - ONE_WORD;
                     OP_RESTORE_ACC:
                     begin
                        sp_r     <= sp_r + ONE_WORD;
                        acc_r    <= mem_in.rdata;
                        flag_r.z <= (mem_in.rdata == ZERO_BYTE);
                     end
                     OP_RESTORE_PAIR:
                     begin
                        sp_r <= sp_r + ONE_WORD;
                        if (step_r)
                           pair_r[pidx][7:0] <= mem_in.rdata;
                        else
                           pair_r[pidx][15:8] <= mem_in.rdata;
                     end
                     OP_BLOCK_COPY:
                        if (step_r)
                        begin
                           pair_r[PAIR_X] <= pair_r[PAIR_X] + ONE_WORD;
                           pair_r[PAIR_Y] <= pair_r[PAIR_Y] + ONE_WORD;
                        end
                     OP_CMP_MEM_ADV:
                     begin
                        flag_r         <= cmp_f(acc_r, mem_in.rdata);
                        pair_r[PAIR_X] <= pair_r[PAIR_X] + ONE_WORD;
                     end
                     OP_CMP_MEM: flag_r <= cmp_f(acc_r, mem_in.rdata);
                     OP_NIB_ROT_LEFT, OP_NIB_ROT_RIGHT:
                        if (step_r)
                           acc_r <= mdat_r;
                  endcase
                  if (m_last)
                     state_r <= ST_IDLE;
                  else
                  begin
                     step_r  <= 1'b1;
                     state_r <= ST_EXEC;
                  end
               end
            end
            default:
            begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: transfer_shift_exec_bench.sv */
// self-checking bench for the transfer and shift execution unit
`default_nettype none
module transfer_shift_exec_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import shift_pkg::*;
   logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, slow;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   mem_req_t    mem_out;
   mem_rsp_t    mem_in;
   int          fails, checks;
   transfer_shift_exec u_dut (.core_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .mem_out, .mem_in);
   mem_model u_mem (.core_clk, .rst_n, .slow, .mem_out, .mem_in);
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
      begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic er);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do
         @(posedge core_clk);
      while (pready !== 1'b1);
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x);
   endtask
   // polls busy so slow memory answers never need a fixed wait
   task automatic run(input logic [5:0] op, input logic [1:0] sl = PAIR_X,
                      input logic [15:0] im = 16'h0000);
      logic [31:0] r;
      logic        e;
      int          n;
      wr(A_CMD, {im, 8'h00, sl, op});
      n = 0;
      do
         apb(1'b0, A_STAT, 32'h0, r, e);
      while (r[BUSY_BIT] !== 1'b0 && ++n < 30);
      chk({31'h0, r[BUSY_BIT]}, 32'h0);
   endtask
   task automatic t_load;
      u_mem.mem[17'h01234] = 8'h00;
      wr(A_XP, 32'h1234);
      run(OP_LOAD_INC);
      rd(A_ACC, 32'h0);
      rd(A_FLAG, 32'h4);
      rd(A_XP, 32'h1235);
   endtask
   task automatic t_store;
      slow <= 1'b1;
      wr(A_ACC, 32'h5a);
      wr(A_YP, 32'h4700);
      run(OP_STORE_DEC, PAIR_Y);
      chk({24'h0, u_mem.mem[17'h04700]}, 32'h5a);
      rd(A_YP, 32'h46ff);
      run(OP_STORE_INC, PAIR_Y);
      chk({24'h0, u_mem.mem[17'h046ff]}, 32'h5a);
      rd(A_YP, 32'h4700);
      rd(A_FLAG, 32'h4);
      slow <= 1'b0;
   endtask
   task automatic t_stack;
      run(OP_LOAD_IMM_STACK, PAIR_X, 16'h0047);
      rd(A_SP, 32'h4700);
      wr(A_XP, 32'h2030);
      run(OP_SAVE_PAIR);
      chk({u_mem.mem[17'h04700], u_mem.mem[17'h046ff]}, 32'h3020);
      rd(A_SP, 32'h46fe);
      run(OP_RESTORE_PAIR, PAIR_Y);
      rd(A_YP, 32'h2030);
      run(OP_SAVE_ACC);
      run(OP_RESTORE_ACC);
      rd(A_SP, 32'h4700);
      rd(A_ACC, 32'h5a);
   endtask
   task automatic t_shift;
      logic [23:0] tb [5] = '{{OP_ROT_LEFT, 8'h5d, 1'b1, 8'hbb, 1'b0},
         {OP_ROT_RIGHT, 8'hc8, 1'b0, 8'h64, 1'b0}, {OP_SHIFT_LEFT, 8'h9d, 1'b0, 8'h3a, 1'b1},
         {OP_SHIFT_RIGHT, 8'h9d, 1'b0, 8'h4e, 1'b1}, {OP_NIB_SWAP, 8'hca, 1'b1, 8'hac, 1'b1}};
      foreach (tb[i])
      begin
         wr(A_FLAG, {31'h0, tb[i][9]});
         wr(A_ACC, {24'h0, tb[i][17:10]});
         run(tb[i][23:18]);
         rd(A_ACC, {24'h0, tb[i][8:1]});
         rd(A_FLAG, {31'h0, tb[i][0]});
      end
   endtask
   task automatic t_digit;
      wr(A_XP, 32'h4700);
      u_mem.mem[17'h04700] = 8'hb3;
      wr(A_ACC, 32'h6f);
      run(OP_NIB_ROT_LEFT);
      rd(A_ACC, 32'hb3);
      chk({24'h0, u_mem.mem[17'h04700]}, 32'h36);
      u_mem.mem[17'h04700] = 8'h42;
      wr(A_ACC, 32'hc1);
      run(OP_NIB_ROT_RIGHT);
      rd(A_ACC, 32'h42);
      chk({24'h0, u_mem.mem[17'h04700]}, 32'h14);
      run(OP_ACC_TO_TEMP);
      rd(A_TMP, 32'h42);
   endtask
   task automatic t_block;
      logic [31:0] r;
      logic        e;
      u_mem.mem[17'h04700] = 8'h33;
      wr(A_YP, 32'h4800);
      run(OP_BLOCK_COPY);
      chk({24'h0, u_mem.mem[17'h04800]}, 32'h33);
      rd(A_XP, 32'h4701);
      rd(A_YP, 32'h4801);
      apb(1'b0, 8'hfc, 32'h0, r, e);
      chk({r[31:1], e}, 32'h1);
   endtask
   task automatic t_misc;
      u_mem.mem[17'h04801] = 8'h42;
      u_mem.mem[17'h04802] = 8'h00;
      run(OP_LOAD_INDEX, PAIR_Y);
      run(OP_CMP_MEM_ADV);
      rd(A_FLAG, 32'h7);
      rd(A_XP, 32'h4802);
      run(OP_CMP_REG);
      rd(A_FLAG, 32'h3);
      run(OP_STORE_INDEX, PAIR_U);
      run(OP_LOAD_DEC, PAIR_U);
      rd(A_ACC, 32'h0);
      rd(A_UP, 32'h4801);
      run(OP_TEMP_TO_ACC);
      rd(A_FLAG, 32'h3);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      core_clk = 1'b0;
      forever
         #10 core_clk = ~core_clk;
   end
   initial
   begin
      {rst_n, psel, penable, pwrite, slow, paddr, pwdata, fails, checks} = '0;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      t_load;
      t_store;
      t_stack;
      t_shift;
      t_digit;
      t_block;
      t_misc;
      tally_and_finish;
   end
   initial
   begin
      #200000;
      fails++;
      tally_and_finish;
   end
endmodule
bind transfer_shift_exec tse_asserts u_chk (.core_clk, .rst_n, .paddr, .psel, .penable,
   .pwrite, .pwdata, .prdata, .pready, .pslverr, .mem_out, .mem_in);
`default_nettype wire

/* File: tse_asserts.sv */
// port checker for the transfer and shift execution unit
`default_nettype none
module tse_asserts (
   input  wire logic                core_clk,
   input  wire logic                rst_n,
   input  wire logic [7:0]          paddr,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [31:0]         pwdata,
   input  wire logic [31:0]         prdata,
   input  wire logic                pready,
   input  wire logic                pslverr,
   input  wire shift_pkg::mem_req_t mem_out,
   input  wire shift_pkg::mem_rsp_t mem_in
);
   import shift_pkg::*;
   logic       go;
   logic [5:0] op;
   assign go = psel & penable & pready & pwrite & (paddr == A_CMD);
   assign op = pwdata[5:0];
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   property p_sav; go && op == OP_SAVE_ACC |-> ##2 mem_out.req && mem_out.we && !mem_out.space;
   endproperty
   a_sav: assert property (p_sav) else $error("save is not a stack write");
   property p_pop; go && op == OP_RESTORE_ACC |-> ##2 mem_out.req && !mem_out.we && !mem_out.space;
   endproperty
   a_pop: assert property (p_pop) else $error("restore is not a stack read");
   property p_lin; go && op == OP_LOAD_INC |-> ##2 mem_out.req && !mem_out.we; endproperty
   a_lin: assert property (p_lin) else $error("load did not read");
   property p_sin; go && op == OP_STORE_INC |-> ##2 mem_out.req && mem_out.we; endproperty
   a_sin: assert property (p_sin) else $error("store did not write");
   property p_hld; mem_out.req && !mem_in.ack |=> mem_out.req && $stable(mem_out); endproperty
   a_hld: assert property (p_hld) else $error("request moved before answer");
   property p_drp; mem_out.req && mem_in.ack |=> !mem_out.req; endproperty
   a_drp: assert property (p_drp) else $error("request kept after answer");
   property p_tmp; go && op == OP_ACC_TO_TEMP |-> ##2 !mem_out.req; endproperty
   a_tmp: assert property (p_tmp) else $error("temp copy touched memory");
   property p_swp; go && op == OP_NIB_SWAP |=> !mem_out.req [*3]; endproperty
   a_swp: assert property (p_swp) else $error("swap touched memory");
   c_go: cover property (go);
   c_wr: cover property (mem_out.req && mem_in.ack && mem_out.we);
   c_err: cover property (pready && pslverr);
endmodule
`default_nettype wire
